// file: design/pmsi_defines.vh
`ifndef PMSI_DEFINES_VH
`define PMSI_DEFINES_VH

// Register offsets (byte addresses)
`define PMSI_OFS_PMCSR 8'h84
`define PMSI_OFS_MSI_CTL 8'h8C
`define PMSI_OFS_MSI_ADDR 8'h90
`define PMSI_OFS_MSI_UADDR 8'h94
`define PMSI_OFS_MSI_DATA 8'h98
`define PMSI_OFS_EVT_STAT 8'hC0
`define PMSI_OFS_EVT_MASK 8'hC4

// Power control/status field positions
`define PMSI_PS_HI 1
`define PMSI_PS_LO 0
`define PMSI_NSR_BIT 3
`define PMSI_PME_EN_BIT 8
`define PMSI_DSEL_HI 12
`define PMSI_DSEL_LO 9
`define PMSI_PME_ST_BIT 15
`define PMSI_B2B3_BIT 22
`define PMSI_BPCC_BIT 23

// Power states
`define PMSI_D0 2'h0
`define PMSI_D1 2'h1
`define PMSI_D2 2'h2
`define PMSI_D3HOT 2'h3

// Message capability fields
`define PMSI_CAP_ID 8'h05
`define PMSI_NEXT_PTR 8'h9C
`define PMSI_MSI_EN_BIT 16
`define PMSI_MMC_HI 19
`define PMSI_MMC_LO 17
`define PMSI_MME_HI 22
`define PMSI_MME_LO 20
`define PMSI_A64_BIT 23
`define PMSI_MMC_VAL 3'h0
`define PMSI_A64_VAL 1'h1

// Reset values
`define PMSI_RST_PS 2'h0
`define PMSI_RST_NSR 1'h0
`define PMSI_RST_MME 3'h0
`define PMSI_RST_ADDR 30'h00000000
`define PMSI_RST_UADDR 32'h00000000
`define PMSI_RST_DATA 16'h0000

// Event status bits
`define PMSI_EVT_W 4
`define PMSI_EVT_HOTRST 0
`define PMSI_EVT_MSI 1
`define PMSI_EVT_PME 2
`define PMSI_EVT_PSCHG 3

// Timing
`define PMSI_CLK_PERIOD_NS 10
`define PMSI_HOT_RST_NS 160
`define PMSI_HOT_RST_CYC ((`PMSI_HOT_RST_NS + `PMSI_CLK_PERIOD_NS - 1) / `PMSI_CLK_PERIOD_NS)

`endif

// file: design/pmsi_regs.v
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "pmsi_defines.vh"

module pmsi_regs #(
    parameter HOT_RST_CYCLES = `PMSI_HOT_RST_CYC
) (
    // Clock and reset
    input wire REF_CLK,
    input wire RST_N,
    // Register port
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    // Serial config memory load
    input wire NVM_LOAD,
    input wire NVM_NO_SOFT_RESET,
    // Function interrupt and wake sources
    input wire IRQ_LEVEL,
    input wire PME_EVENT,
    // Message write request to the link
    output reg MSI_WR_REQ,
    output reg [63:0] MSI_WR_ADDR,
    output reg [15:0] MSI_WR_DATA,
    input wire MSI_WR_ACK,
    // Power management message request
    output reg PME_MSG_REQ,
    input wire PME_MSG_ACK,
    // Legacy wire interrupt
    output reg LEGACY_INTX,
    // Power state and internal reset
    output reg [1:0] POWER_STATE,
    output reg HOT_RESET,
    // Event interrupt
    output reg IRQ
);

    localparam [7:0] HOT_RST_CNT = HOT_RST_CYCLES[7:0];

    // Message sequencer states
    localparam [1:0] MS_IDLE = 2'h0;
    localparam [1:0] MS_REQ = 2'h1;
    localparam [1:0] MS_GAP = 2'h2;

    // Register state
    reg [1:0] ps_q;
    reg no_soft_reset_q;
    reg pme_en_q;
    reg [3:0] data_sel_q;
    reg pme_pend_q;
    reg msi_en_q;
    reg [2:0] mme_q;
    reg [29:0] addr_q;
    reg [31:0] uaddr_q;
    reg [15:0] data_q;
    reg [`PMSI_EVT_W-1:0] stat_q;
    reg [`PMSI_EVT_W-1:0] mask_q;
    reg [7:0] rst_cnt_q;
    reg irq_lvl_q;
    reg msi_pend_q;
    reg [1:0] ms_state_q;

    // Decoded strobes
    wire wr_pmcsr = REG_WR && (REG_ADDR == `PMSI_OFS_PMCSR);
    wire wr_ctl = REG_WR && (REG_ADDR == `PMSI_OFS_MSI_CTL);
    wire wr_addr = REG_WR && (REG_ADDR == `PMSI_OFS_MSI_ADDR);
    wire wr_uaddr = REG_WR && (REG_ADDR == `PMSI_OFS_MSI_UADDR);
    wire wr_data = REG_WR && (REG_ADDR == `PMSI_OFS_MSI_DATA);
    wire wr_stat = REG_WR && (REG_ADDR == `PMSI_OFS_EVT_STAT);
    wire wr_mask = REG_WR && (REG_ADDR == `PMSI_OFS_EVT_MASK);

    // Leaving D3hot for D0 by a software write, and any power control write that changes the state
    wire new_ps_d0 = REG_WDATA[`PMSI_PS_HI:`PMSI_PS_LO] == `PMSI_D0;
    wire d3_exit = wr_pmcsr && new_ps_d0 && (ps_q == `PMSI_D3HOT);
    wire hot_start = d3_exit && !no_soft_reset_q;
    wire ps_change = wr_pmcsr && (REG_WDATA[`PMSI_PS_HI:`PMSI_PS_LO] != ps_q);

    // Interrupt source edge, same clock so no synchroniser needed
    wire irq_rise = IRQ_LEVEL && !irq_lvl_q;

    // Next enable, so the wire drops in the very cycle messages take over
    wire msi_en_d = HOT_RESET ? 1'b0 : (wr_ctl ? REG_WDATA[`PMSI_MSI_EN_BIT] : msi_en_q);

    // Message and PME completion pulses
    wire msi_done = (ms_state_q == MS_REQ) && MSI_WR_ACK;
    wire pme_done = PME_MSG_REQ && PME_MSG_ACK;

    // Assembled read words
    wire [31:0] pmcsr_word;
    wire [31:0] ctl_word;
    assign pmcsr_word = {8'h00, 1'b0, 1'b0, 6'h00,
                         pme_pend_q, 2'h0, data_sel_q, pme_en_q,
                         4'h0, no_soft_reset_q, 1'b0, ps_q};
    assign ctl_word = {8'h00, `PMSI_A64_VAL, mme_q, `PMSI_MMC_VAL,
                       msi_en_q, `PMSI_NEXT_PTR, `PMSI_CAP_ID};

    // Power state, skip flag and PME enable
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ps_q <= `PMSI_RST_PS;
            no_soft_reset_q <= `PMSI_RST_NSR;
            pme_en_q <= 1'b0;
            data_sel_q <= 4'h0;
        end else begin
            if (wr_pmcsr) begin
                ps_q <= REG_WDATA[`PMSI_PS_HI:`PMSI_PS_LO];
                pme_en_q <= REG_WDATA[`PMSI_PME_EN_BIT];
                data_sel_q <= REG_WDATA[`PMSI_DSEL_HI:`PMSI_DSEL_LO];
            end
            // Memory loader overrides the default once it has read the part
            if (NVM_LOAD) begin
                no_soft_reset_q <= NVM_NO_SOFT_RESET;
            end
        end
    end

    // Internal reset timer; the pin reset is never touched here
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_cnt_q <= 8'h00;
            HOT_RESET <= 1'b0;
        end else begin
            if (hot_start) begin
                rst_cnt_q <= HOT_RST_CNT;
                HOT_RESET <= 1'b1;
            end else if (rst_cnt_q > 8'h01) begin
                rst_cnt_q <= rst_cnt_q - 8'h01;
            end else begin
                rst_cnt_q <= 8'h00;
                HOT_RESET <= 1'b0;
            end
        end
    end

    // Message capability registers; the internal reset returns them to defaults
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            msi_en_q <= 1'b0;
            mme_q <= `PMSI_RST_MME;
            addr_q <= `PMSI_RST_ADDR;
            uaddr_q <= `PMSI_RST_UADDR;
            data_q <= `PMSI_RST_DATA;
        end else if (HOT_RESET) begin
            msi_en_q <= 1'b0;
            mme_q <= `PMSI_RST_MME;
            addr_q <= `PMSI_RST_ADDR;
            uaddr_q <= `PMSI_RST_UADDR;
            data_q <= `PMSI_RST_DATA;
        end else begin
            if (wr_ctl) begin
                msi_en_q <= REG_WDATA[`PMSI_MSI_EN_BIT];
                mme_q <= REG_WDATA[`PMSI_MME_HI:`PMSI_MME_LO];
            end
            if (wr_addr) begin
                addr_q <= REG_WDATA[31:2];
            end
            if (wr_uaddr) begin
                uaddr_q <= REG_WDATA;
            end
            if (wr_data) begin
                data_q <= REG_WDATA[15:0];
            end
        end
    end

    // PME pending: held while disabled, cleared when the message leaves
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pme_pend_q <= 1'b0;
            PME_MSG_REQ <= 1'b0;
        end else begin
            if (PME_EVENT) begin
                pme_pend_q <= 1'b1;
            end else if (pme_done) begin
                pme_pend_q <= 1'b0;
            end
            // A new event beside an ack keeps the pending bit; the request drops and rises again one cycle later
            if (pme_done) begin
                PME_MSG_REQ <= 1'b0;
            end else if (pme_pend_q && pme_en_q) begin
                PME_MSG_REQ <= 1'b1;
            end
        end
    end

    // Interrupt edge capture and legacy wire
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_lvl_q <= 1'b0;
            LEGACY_INTX <= 1'b0;
        end else begin
            irq_lvl_q <= IRQ_LEVEL;
            // Wire follows the next enable, never overlapping an enabled cycle
            LEGACY_INTX <= IRQ_LEVEL && !msi_en_d;
        end
    end

    // Pending message: set wins over the clear taken while the sequencer is idle
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            msi_pend_q <= 1'b0;
        end else if (!msi_en_q) begin
            msi_pend_q <= 1'b0;
        end else if (irq_rise) begin
            msi_pend_q <= 1'b1;
        end else if (ms_state_q == MS_IDLE) begin
            msi_pend_q <= 1'b0;
        end
    end

    // Message write sequencer; address and data frozen for the whole request
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ms_state_q <= MS_IDLE;
            MSI_WR_REQ <= 1'b0;
            MSI_WR_ADDR <= 64'h0000000000000000;
            MSI_WR_DATA <= 16'h0000;
        end else begin
            case (ms_state_q)
                MS_IDLE: begin
                    if (msi_pend_q && msi_en_q) begin
                        ms_state_q <= MS_REQ;
                        MSI_WR_REQ <= 1'b1;
                        MSI_WR_ADDR <= {uaddr_q, addr_q, 2'h0};
                        MSI_WR_DATA <= data_q;
                    end
                end
                MS_REQ: begin
                    if (MSI_WR_ACK) begin
                        ms_state_q <= MS_GAP;
                        MSI_WR_REQ <= 1'b0;
                    end
                end
                MS_GAP: begin
                    // One idle cycle so each event yields exactly one write
                    ms_state_q <= MS_IDLE;
                end
                default: begin
                    ms_state_q <= MS_IDLE;
                    MSI_WR_REQ <= 1'b0;
                end
            endcase
        end
    end

    // Event status, write one to clear; a same-cycle event wins
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stat_q <= {`PMSI_EVT_W{1'b0}};
            mask_q <= {`PMSI_EVT_W{1'b0}};
        end else begin
            if (wr_mask) begin
                mask_q <= REG_WDATA[`PMSI_EVT_W-1:0];
            end
            stat_q <= (stat_q & ~(wr_stat ? REG_WDATA[`PMSI_EVT_W-1:0] : 4'h0))
                      | {ps_change, pme_done, msi_done, hot_start};
        end
    end

    // Interrupt output and power state mirror
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
            POWER_STATE <= `PMSI_RST_PS;
        end else begin
            IRQ <= |(stat_q & mask_q);
            POWER_STATE <= ps_q;
        end
    end

    // Read data one cycle after the strobe, zero otherwise and for holes
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `PMSI_OFS_PMCSR: REG_RDATA <= pmcsr_word;
                `PMSI_OFS_MSI_CTL: REG_RDATA <= ctl_word;
                `PMSI_OFS_MSI_ADDR: REG_RDATA <= {addr_q, 2'h0};
                `PMSI_OFS_MSI_UADDR: REG_RDATA <= uaddr_q;
                `PMSI_OFS_MSI_DATA: REG_RDATA <= {16'h0000, data_q};
                `PMSI_OFS_EVT_STAT: REG_RDATA <= {28'h0000000, stat_q};
                `PMSI_OFS_EVT_MASK: REG_RDATA <= {28'h0000000, mask_q};
                default: REG_RDATA <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

endmodule // pmsi_regs

// file: bench/pmsi_regs_monitor.sv
`timescale 1ns/1ns
module pmsi_regs_monitor #(
    parameter HOT_RST_CYCLES = 16
) (
    // Clock, reset and register port
    input wire REF_CLK,
    input wire RST_N,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [31:0] REG_RDATA,
    // Message, wake and reset outputs
    input wire MSI_WR_REQ,
    input wire [63:0] MSI_WR_ADDR,
    input wire [15:0] MSI_WR_DATA,
    input wire MSI_WR_ACK,
    input wire PME_MSG_REQ,
    input wire LEGACY_INTX,
    input wire HOT_RESET
);
    reg msi_en_q;
    reg pme_en_q;
    reg [7:0] hr_cnt_q;
    // Shadow enables; a lost write during hot reset is ignored here too
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            msi_en_q <= 1'b0;
            pme_en_q <= 1'b0;
            hr_cnt_q <= 8'h00;
        end else begin
            if (HOT_RESET) msi_en_q <= 1'b0;
            else if (REG_WR && REG_ADDR == 8'h8C) msi_en_q <= REG_WDATA[16];
            if (REG_WR && REG_ADDR == 8'h84) pme_en_q <= REG_WDATA[8];
            hr_cnt_q <= HOT_RESET ? hr_cnt_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Fixed fields seen on reads
    a_cap_header: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h8C |->
        REG_RDATA[15:0] == 16'h9C05) else $error("capability header wrong");
    a_ctl_fixed_bits: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h8C |->
        REG_RDATA[19:17] == 3'h0 && REG_RDATA[23]) else $error("control fixed bits wrong");
    a_pm_upper_zero: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h84 |->
        REG_RDATA[31:22] == 10'h000) else $error("power word upper bits set");
    a_addr_aligned: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h90 |->
        REG_RDATA[1:0] == 2'h0) else $error("address low bits set");
    // Hot reset length and cause
    a_hot_rst_len: assert property ($fell(HOT_RESET) |-> hr_cnt_q == HOT_RST_CYCLES)
        else $error("hot reset length wrong");
    a_hot_rst_cause: assert property ($rose(HOT_RESET) |-> $past(REG_WR) &&
        $past(REG_ADDR) == 8'h84 && $past(REG_WDATA[1:0]) == 2'h0) else $error("stray hot reset");
    // Message write handshake
    a_msi_req_hold: assert property (MSI_WR_REQ && !MSI_WR_ACK |=> MSI_WR_REQ &&
        $stable(MSI_WR_ADDR) && $stable(MSI_WR_DATA)) else $error("message request dropped");
    a_msi_single: assert property (MSI_WR_REQ && MSI_WR_ACK |=> !MSI_WR_REQ)
        else $error("message request repeated");
    a_msi_gated: assert property ($rose(MSI_WR_REQ) |-> $past(msi_en_q))
        else $error("message while disabled");
    a_intx_quiet: assert property (msi_en_q |-> !LEGACY_INTX)
        else $error("wire interrupt while messages on");
    a_pme_gated: assert property ($rose(PME_MSG_REQ) |-> $past(pme_en_q))
        else $error("wake message while disabled");
    cover property ($fell(HOT_RESET));
    cover property (MSI_WR_REQ && MSI_WR_ACK);
    cover property ($rose(PME_MSG_REQ));
endmodule // pmsi_regs_monitor

// file: bench/pmsi_host_model.sv
`timescale 1ns/1ns
module pmsi_host_model (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Requests and pacing
    input wire msi_req,
    input wire pme_req,
    input wire slow,
    // Acknowledges
    output reg msi_ack,
    output reg pme_ack
);
    reg [2:0] msi_cnt_q;
    reg [2:0] pme_cnt_q;
    // One ack pulse per request; a slow host waits four cycles first
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msi_ack <= 1'b0;
            pme_ack <= 1'b0;
            msi_cnt_q <= 3'h0;
            pme_cnt_q <= 3'h0;
        end else begin
            msi_ack <= msi_req && !msi_ack && msi_cnt_q >= {slow, 2'h0};
            msi_cnt_q <= (msi_req && !msi_ack) ? msi_cnt_q + 3'h1 : 3'h0;
            pme_ack <= pme_req && !pme_ack && pme_cnt_q >= {slow, 2'h0};
            pme_cnt_q <= (pme_req && !pme_ack) ? pme_cnt_q + 3'h1 : 3'h0;
        end
    end
endmodule // pmsi_host_model

// file: bench/pmsi_regs_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module pmsi_regs_tb;
    reg REF_CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, slow = 1'b0;
    reg NVM_LOAD = 1'b0, NVM_NO_SOFT_RESET = 1'b0, IRQ_LEVEL = 1'b0, PME_EVENT = 1'b0;
    reg [7:0] REG_ADDR = 8'h00;
    reg [31:0] REG_WDATA = 32'h00000000;
    wire [31:0] REG_RDATA;
    wire [63:0] MSI_WR_ADDR;
    wire [15:0] MSI_WR_DATA;
    wire [1:0] POWER_STATE;
    wire MSI_WR_REQ, MSI_WR_ACK, PME_MSG_REQ, PME_MSG_ACK, LEGACY_INTX, HOT_RESET, IRQ;
    integer num_errors = 0, cmp_count = 0, cyc = 0, i;
    pmsi_regs #(.HOT_RST_CYCLES(4)) uut (.REF_CLK(REF_CLK), .RST_N(RST_N),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .NVM_LOAD(NVM_LOAD), .NVM_NO_SOFT_RESET(NVM_NO_SOFT_RESET),
        .IRQ_LEVEL(IRQ_LEVEL), .PME_EVENT(PME_EVENT), .MSI_WR_REQ(MSI_WR_REQ),
        .MSI_WR_ADDR(MSI_WR_ADDR), .MSI_WR_DATA(MSI_WR_DATA), .MSI_WR_ACK(MSI_WR_ACK),
        .PME_MSG_REQ(PME_MSG_REQ), .PME_MSG_ACK(PME_MSG_ACK), .LEGACY_INTX(LEGACY_INTX),
        .POWER_STATE(POWER_STATE), .HOT_RESET(HOT_RESET), .IRQ(IRQ));
    pmsi_host_model host (.clk(REF_CLK), .rst_n(RST_N), .msi_req(MSI_WR_REQ),
        .pme_req(PME_MSG_REQ), .slow(slow), .msi_ack(MSI_WR_ACK), .pme_ack(PME_MSG_ACK));
    // Clock and hang guard
    always #5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results;
        end
    end
    task results;
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bus cycles and waits
    task wr(input [7:0] a, input [31:0] d);
        @(posedge REF_CLK) begin REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1; end
        @(posedge REF_CLK) REG_WR <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge REF_CLK) begin REG_ADDR <= a; REG_RD <= 1'b1; end
        @(posedge REF_CLK) REG_RD <= 1'b0;
        #1 `CHK(REG_RDATA, e)
    endtask
    task clk_n(input integer n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task wait_msi(input lvl);
        for (i = 0; i < 30 && MSI_WR_REQ !== lvl; i++) clk_n(1);
    endtask
    // Reset values and an unmapped place
    task t_reset_vals;
        rd(8'h84, 32'h00000000);
        rd(8'h8C, 32'h00809C05);
        rd(8'h90, 32'h00000000);
        rd(8'h94, 32'h00000000);
        rd(8'h98, 32'h00000000);
        rd(8'hF0, 32'h00000000);
    endtask
    // Program first, then enable; one write per edge, then interrupt path
    task t_msi_write;
        wr(8'h90, 32'hABCD0013);
        wr(8'h94, 32'h12345678);
        wr(8'h98, 32'h0001BEEF);
        wr(8'h8C, 32'hFFFFFFFF);
        rd(8'h90, 32'hABCD0010);
        rd(8'h8C, 32'h00F19C05);
        slow <= 1'b1;
        @(posedge REF_CLK) IRQ_LEVEL <= 1'b1;
        wait_msi(1'b1);
        `CHK(MSI_WR_ADDR, 64'h12345678ABCD0010)
        `CHK(MSI_WR_DATA, 16'hBEEF)
        `CHK(LEGACY_INTX, 1'b0)
        wait_msi(1'b0);
        clk_n(6);
        `CHK(MSI_WR_REQ, 1'b0)
        `CHK(IRQ, 1'b0)
        wr(8'hC4, 32'h00000002);
        clk_n(2);
        `CHK(IRQ, 1'b1)
        wr(8'hC0, 32'h00000002);
        clk_n(2);
        `CHK(IRQ, 1'b0)
    endtask
    // Disabled: edges dropped, wire interrupt follows the level
    task t_msi_off;
        wr(8'h8C, 32'h00000000);
        @(posedge REF_CLK) IRQ_LEVEL <= 1'b0;
        clk_n(2);
        @(posedge REF_CLK) IRQ_LEVEL <= 1'b1;
        clk_n(6);
        `CHK(MSI_WR_REQ, 1'b0)
        `CHK(LEGACY_INTX, 1'b1)
    endtask
    // Every power state code; read-only and hardwired bits stay put
    task t_power;
        for (int s = 0; s < 4; s++) begin
            wr(8'h84, {30'h3FFFFFFF, s[1:0]});
            rd(8'h84, {20'h00001, 10'h3C0, s[1:0]});
            `CHK(POWER_STATE, s[1:0])
        end
    endtask
    // Wake event pending until the slow host acks it
    task t_pme;
        @(posedge REF_CLK) PME_EVENT <= 1'b1;
        @(posedge REF_CLK) PME_EVENT <= 1'b0;
        clk_n(1);
        `CHK(PME_MSG_REQ, 1'b1)
        rd(8'h84, 32'h00009F03);
        for (i = 0; i < 30 && PME_MSG_REQ !== 1'b0; i++) clk_n(1);
        rd(8'h84, 32'h00001F03);
    endtask
    // D3hot to D0 resets the message side unless the skip flag is loaded
    task t_hot;
        wr(8'h84, 32'h00000100);
        #1 `CHK(HOT_RESET, 1'b1)
        for (i = 0; i < 40 && HOT_RESET === 1'b1; i++) clk_n(1);
        `CHK(i, 4)
        rd(8'h8C, 32'h00809C05);
        rd(8'h94, 32'h00000000);
        rd(8'h98, 32'h00000000);
        rd(8'hC0, 32'h0000000D);
        @(posedge REF_CLK) begin NVM_NO_SOFT_RESET <= 1'b1; NVM_LOAD <= 1'b1; end
        @(posedge REF_CLK) NVM_LOAD <= 1'b0;
        rd(8'h84, 32'h00000108);
        wr(8'h84, 32'h00000003);
        wr(8'h84, 32'h00000000);
        clk_n(3);
        `CHK(HOT_RESET, 1'b0)
    endtask
    // Pin reset mid-run drops the loaded skip flag and the power word
    task t_rst_mid;
        @(posedge REF_CLK) RST_N <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rd(8'h84, 32'h00000000);
    endtask
    initial begin
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_reset_vals;
        t_msi_write;
        t_msi_off;
        t_power;
        t_pme;
        t_hot;
        t_rst_mid;
        results;
    end
endmodule // pmsi_regs_tb
bind pmsi_regs pmsi_regs_monitor #(.HOT_RST_CYCLES(HOT_RST_CYCLES)) mon (.REF_CLK(REF_CLK),
    .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MSI_WR_REQ(MSI_WR_REQ), .MSI_WR_ADDR(MSI_WR_ADDR),
    .MSI_WR_DATA(MSI_WR_DATA), .MSI_WR_ACK(MSI_WR_ACK), .PME_MSG_REQ(PME_MSG_REQ),
    .LEGACY_INTX(LEGACY_INTX), .HOT_RESET(HOT_RESET));
